// ---- logic/cdc_pkg.sv ----
// Package of constants and types for the comparator digital control block.
`default_nettype none

package cdc_pkg;

   // ****************************************************************
   // Register map and bus widths.
   // ****************************************************************
   localparam int unsigned ADDR_W = 3;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned NUM_CMP = 2;
   localparam logic [2:0] OFF_CTRL_PRI_ONE = 3'h0;
   localparam logic [2:0] OFF_CTRL_SEC_ONE = 3'h1;
   localparam logic [2:0] OFF_CTRL_PRI_TWO = 3'h2;
   localparam logic [2:0] OFF_CTRL_SEC_TWO = 3'h3;
   localparam logic [2:0] OFF_MIRROR = 3'h4;
   localparam logic [2:0] OFF_IRQ_FLAG = 3'h5;

   // ****************************************************************
   // Primary control register fields and reset value.
   // ****************************************************************
   localparam int unsigned PRI_ENABLE = 7;
   localparam int unsigned PRI_RESULT = 6;
   localparam int unsigned PRI_PIN_DRIVE = 5;
   localparam int unsigned PRI_INVERT = 4;
   localparam int unsigned PRI_SPEED = 2;
   localparam int unsigned PRI_HYST = 1;
   localparam int unsigned PRI_SYNC = 0;
   localparam logic [7:0] PRI_WR_MASK = 8'hB7;
   localparam logic [7:0] PRI_RESET = 8'h04;

   // ****************************************************************
   // Secondary control register fields and reset value.
   // ****************************************************************
   localparam int unsigned SEC_RISE_EN = 7;
   localparam int unsigned SEC_FALL_EN = 6;
   localparam int unsigned SEC_PLUS_LSB = 4;
   localparam int unsigned SEC_MINUS_LSB = 0;
   localparam logic [7:0] SEC_WR_MASK = 8'hF3;
   localparam logic [7:0] SEC_RESET = 8'h00;

   // ****************************************************************
   // Mirror and flag register reset values.
   // ****************************************************************
   localparam logic [1:0] MIRROR_RESET = 2'h0;
   localparam logic [1:0] FLAG_RESET = 2'h0;

   // ****************************************************************
   // Input channel codes for the non-inverting node.
   // ****************************************************************
   localparam logic [1:0] PLUS_PIN = 2'h0;
   localparam logic [1:0] PLUS_DAC = 2'h1;
   localparam logic [1:0] PLUS_FIXED_REF = 2'h2;
   localparam logic [1:0] PLUS_GROUND = 2'h3;

   // Register bus request from software.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } cdc_bus_req_t;

   // Controls toward one analog comparator core.
   typedef struct packed {
      logic connect;
      logic [1:0] plus_sel;
      logic [1:0] minus_sel;
      logic speed_high;
      logic hyst_en;
   } cdc_analog_ctrl_t;

   // Pin-facing signals of one comparator output pin.
   typedef struct packed {
      logic value;
      logic oe;
   } cdc_pin_t;

endpackage

`default_nettype wire

// ---- logic/cdc_comparator_control.sv ----
// Digital control of two analog comparators: registers, polarity, sync, edges.
//
// The register offsets and the plain strobed port were decided locally.
`default_nettype none

// Contract
// RL1: sync bit latches output on timer fall
// RL2: prescaled timer clock used when prescaler active
// RL3: latch on falling edge, timer counts rising
// RL4: enabled rise/fall edges set interrupt flag
// RL5: software clears flag, hardware never does
// RL6: edge during clear keeps flag set
// RL7: toggling invert or enable can set flag
// RL8: software sets all enables for interrupt
// RL9: plus select routes pin, DAC, reference, ground
// RL10: minus select picks shared pin zero-three
// RL11: disabled comparator disconnects all inputs
// RL12: invert bit four flips the result
// RL13: result bit reflects polarity corrected compare
// RL14: pin drive overrides latch when direction clear
// RL15: primary register layout, speed resets one
// RL16: speed bit drives analog power mode
// RL17: sync bit selects timer and pin path
// RL18: secondary edge enables, bits three-two zero
// RL19: mirror register holds both result bits
// RL20: mirror bits seven-two read zero
// RL21: raw high when plus exceeds minus
// RL22: internal result registered every cycle
// RL23: raw results synchronised before edge detection
module cdc_comparator_control (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Register port.
   input wire cdc_pkg::cdc_bus_req_t bus_req_in,
   output logic [7:0] bus_rdata_out,
   // Analog cores, raw results from a foreign timing domain.
   input wire logic [1:0] cmp_raw_in,
   output cdc_pkg::cdc_analog_ctrl_t [1:0] cmp_analog_ctrl_out,
   // Timer clock sources, both asynchronous to clock_in.
   input wire logic timer_src_clk_in,
   input wire logic timer_prescaled_clk_in,
   input wire logic timer_prescaler_active_in,
   output logic [1:0] timer_gate_out,
   // Output pins.
   input wire logic [1:0] pin_direction_bit_in,
   input wire logic [1:0] port_latch_in,
   output cdc_pkg::cdc_pin_t [1:0] cmp_pin_out,
   // Interrupt flags toward the interrupt controller.
   output logic [1:0] cmp_irq_flag_out
);

   // ****************************************************************
   // State of the block.
   // ****************************************************************

   // Every flip-flop of the module lives in this one record.
   typedef struct packed {
      logic [1:0][7:0] pri;
      logic [1:0][7:0] sec;
      logic [1:0] raw_s1;
      logic [1:0] raw_s2;
      logic [1:0] raw_s3;
      logic [1:0] raw_f;
      logic [2:0] tsrc_s;
      logic tsrc_f;
      logic [2:0] tpre_s;
      logic tpre_f;
      logic [1:0] result;
      logic [1:0] sync_latch;
      logic [1:0] gate;
      logic [1:0] flag;
      cdc_pkg::cdc_pin_t [1:0] pin;
      cdc_pkg::cdc_analog_ctrl_t [1:0] ana;
      logic [7:0] rdata;
   } cdc_state_t;

   cdc_state_t state_q;
   cdc_state_t state_d;

   // Decoded register strobes.
   logic [1:0] wr_pri;
   logic [1:0] wr_sec;
   logic wr_flag;

   // Timer clock falling edges after the three-stage filter.
   logic tsrc_fall;
   logic tpre_fall;
   logic timer_fall;

   // Per-comparator intermediate values.
   logic [1:0] raw_next;
   logic [1:0] result_next;
   logic [1:0] rise;
   logic [1:0] fall;
   logic [1:0] set_flag;
   logic [1:0] out_path;

   // ****************************************************************
   // Register decode.
   // ****************************************************************

   // Write strobes for each software-visible register except the read-only mirror.
   assign wr_pri[0] = bus_req_in.wr && (bus_req_in.addr == cdc_pkg::OFF_CTRL_PRI_ONE);
   assign wr_pri[1] = bus_req_in.wr && (bus_req_in.addr == cdc_pkg::OFF_CTRL_PRI_TWO);
   assign wr_sec[0] = bus_req_in.wr && (bus_req_in.addr == cdc_pkg::OFF_CTRL_SEC_ONE);
   assign wr_sec[1] = bus_req_in.wr && (bus_req_in.addr == cdc_pkg::OFF_CTRL_SEC_TWO);
   assign wr_flag = bus_req_in.wr && (bus_req_in.addr == cdc_pkg::OFF_IRQ_FLAG);

   // ****************************************************************
   // Timer clock edge detection.
   // ****************************************************************

   // A falling edge counts once the second and third stages agree on low
   // while the filtered level was still high.
   assign tsrc_fall = (state_q.tsrc_s[1] == state_q.tsrc_s[2]) && !state_q.tsrc_s[2]
                      && state_q.tsrc_f;
   assign tpre_fall = (state_q.tpre_s[1] == state_q.tpre_s[2]) && !state_q.tpre_s[2]
                      && state_q.tpre_f;

   // The prescaled clock takes over whenever the timer prescaler is active.
   assign timer_fall = timer_prescaler_active_in ? tpre_fall : tsrc_fall; // RL2

   // ****************************************************************
   // Per-comparator result, edge and output path logic.
   // ****************************************************************

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cmp
         // Filtered raw result: adopt the third stage only when it agrees
         // with the second, so a metastable first stage never leaks out.
         assign raw_next[gi] = (state_q.raw_s2[gi] == state_q.raw_s3[gi]) ?
                               state_q.raw_s3[gi] : state_q.raw_f[gi]; // RL23

         // A disabled core reads as low, so the result still follows the
         // invert bit and toggling enable can make an edge.
         assign result_next[gi] =
            (state_q.pri[gi][cdc_pkg::PRI_ENABLE] & raw_next[gi]) // RL21 RL7
            ^ state_q.pri[gi][cdc_pkg::PRI_INVERT]; // RL12 RL13

         // Edges seen on the registered result bit.
         assign rise[gi] = result_next[gi] & ~state_q.result[gi]; // RL4
         assign fall[gi] = ~result_next[gi] & state_q.result[gi]; // RL4

         // Only edges whose enable bit is set may raise the flag.
         assign set_flag[gi] = (rise[gi] & state_q.sec[gi][cdc_pkg::SEC_RISE_EN])
                               | (fall[gi] & state_q.sec[gi][cdc_pkg::SEC_FALL_EN]); // RL4

         // Timer and pin see either the latched or the live result.
         assign out_path[gi] = state_q.pri[gi][cdc_pkg::PRI_SYNC] ?
                               state_q.sync_latch[gi] : state_q.result[gi]; // RL17
      end
   endgenerate

   // ****************************************************************
   // Next-state logic.
   // ****************************************************************

   // Computes the full next state from the current state and the inputs.
   always_comb begin
      state_d = state_q;

      // Three-stage capture of foreign inputs.
      state_d.raw_s1 = cmp_raw_in;
      state_d.raw_s2 = state_q.raw_s1;
      state_d.raw_s3 = state_q.raw_s2;
      state_d.raw_f = raw_next; // RL23
      state_d.tsrc_s = {state_q.tsrc_s[1:0], timer_src_clk_in};
      state_d.tpre_s = {state_q.tpre_s[1:0], timer_prescaled_clk_in};
      if (state_q.tsrc_s[1] == state_q.tsrc_s[2]) begin
         state_d.tsrc_f = state_q.tsrc_s[2];
      end
      if (state_q.tpre_s[1] == state_q.tpre_s[2]) begin
         state_d.tpre_f = state_q.tpre_s[2];
      end

      // Internal result is registered on every clock.
      state_d.result = result_next; // RL22

      for (int i = 0; i < 2; i++) begin
         // Software writes keep only the implemented writable bits.
         if (wr_pri[i]) begin
            state_d.pri[i] = bus_req_in.wdata & cdc_pkg::PRI_WR_MASK; // RL15
         end
         if (wr_sec[i]) begin
            state_d.sec[i] = bus_req_in.wdata & cdc_pkg::SEC_WR_MASK; // RL18
         end

         // The latch only moves on a timer falling edge, away from the
         // rising edge on which the timer counts.
         if (timer_fall) begin
            state_d.sync_latch[i] = state_q.result[i]; // RL1 RL3
         end

         // Hardware only sets the flag; a clear in the same cycle loses.
         state_d.flag[i] = (state_q.flag[i] & ~(wr_flag & bus_req_in.wdata[i]))
                           | set_flag[i]; // RL5 RL6

         // Timer gate follows the selected output path.
         state_d.gate[i] = out_path[i]; // RL17

         // Pin drive overrides the port latch; enable does not matter.
         state_d.pin[i].value = state_q.pri[i][cdc_pkg::PRI_PIN_DRIVE] ?
                                out_path[i] : port_latch_in[i]; // RL14
         state_d.pin[i].oe = ~pin_direction_bit_in[i]; // RL14

         // Analog core controls; a disabled core has every input open.
         state_d.ana[i].connect = state_q.pri[i][cdc_pkg::PRI_ENABLE]; // RL11
         state_d.ana[i].plus_sel =
            state_q.sec[i][cdc_pkg::SEC_PLUS_LSB +: 2]; // RL9
         state_d.ana[i].minus_sel =
            state_q.sec[i][cdc_pkg::SEC_MINUS_LSB +: 2]; // RL10
         state_d.ana[i].speed_high = state_q.pri[i][cdc_pkg::PRI_SPEED]; // RL16
         state_d.ana[i].hyst_en = state_q.pri[i][cdc_pkg::PRI_HYST];
      end

      // Read data stands only in the cycle after the read strobe.
      state_d.rdata = 8'h00;
      if (bus_req_in.rd) begin
         unique case (bus_req_in.addr)
            cdc_pkg::OFF_CTRL_PRI_ONE: begin
               state_d.rdata = state_q.pri[0];
               state_d.rdata[cdc_pkg::PRI_RESULT] = state_q.result[0]; // RL13
            end
            cdc_pkg::OFF_CTRL_PRI_TWO: begin
               state_d.rdata = state_q.pri[1];
               state_d.rdata[cdc_pkg::PRI_RESULT] = state_q.result[1]; // RL13
            end
            cdc_pkg::OFF_CTRL_SEC_ONE: begin
               state_d.rdata = state_q.sec[0]; // RL18
            end
            cdc_pkg::OFF_CTRL_SEC_TWO: begin
               state_d.rdata = state_q.sec[1]; // RL18
            end
            cdc_pkg::OFF_MIRROR: begin
               state_d.rdata = {6'h00, state_q.result}; // RL19 RL20
            end
            cdc_pkg::OFF_IRQ_FLAG: begin
               state_d.rdata = {6'h00, state_q.flag};
            end
            default: begin
               state_d.rdata = 8'h00;
            end
         endcase
      end
   end

   // ****************************************************************
   // State register.
   // ****************************************************************

   // Registers the whole state; reset loads the register reset values.
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= '0;
         state_q.pri <= {cdc_pkg::PRI_RESET, cdc_pkg::PRI_RESET}; // RL15
         state_q.sec <= {cdc_pkg::SEC_RESET, cdc_pkg::SEC_RESET};
         state_q.result <= cdc_pkg::MIRROR_RESET; // RL19
         state_q.flag <= cdc_pkg::FLAG_RESET;
         state_q.pin <= {2{1'b0, 1'b1}};
         state_q.ana <= {2{7'h02}};
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************************************
   // Outputs, each straight from the state register.
   // ****************************************************************

   // Drive all outputs from registered state.
   assign bus_rdata_out = state_q.rdata;
   assign cmp_analog_ctrl_out = state_q.ana;
   assign timer_gate_out = state_q.gate;
   assign cmp_pin_out = state_q.pin;
   assign cmp_irq_flag_out = state_q.flag;

endmodule

`default_nettype wire

// ---- bench/cdc_comparator_control_asserts.sv ----
// Checker of port relations for the comparator control block.
`default_nettype none
module cdc_comparator_control_asserts (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Register port.
   input wire cdc_pkg::cdc_bus_req_t bus_req_in,
   input wire logic [7:0] bus_rdata_out,
   // Analog, pin and flag side.
   input wire cdc_pkg::cdc_analog_ctrl_t [1:0] cmp_analog_ctrl_out,
   input wire logic [1:0] pin_direction_bit_in,
   input wire cdc_pkg::cdc_pin_t [1:0] cmp_pin_out,
   input wire logic [1:0] timer_gate_out,
   input wire logic [1:0] cmp_irq_flag_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************************************
   // Assertions and covers.
   // ****************************************************************
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // Read data stand for one cycle after a read and are zero otherwise.
   rdata_idle_zero_a: assert property (!$past(bus_req_in.rd) |-> bus_rdata_out == 8'h00)
      else $error("Read data not zero outside a read.");
   pri_gap_zero_a: assert property (
      $past(bus_req_in.rd) && $past(bus_req_in.addr[0]) == 1'b0 && !$past(bus_req_in.addr[2])
      |-> bus_rdata_out[3] == 1'b0) else $error("Primary bit three not zero.");
   sec_gap_zero_a: assert property (
      $past(bus_req_in.rd) && $past(bus_req_in.addr[0]) && !$past(bus_req_in.addr[2])
      |-> bus_rdata_out[3:2] == 2'h0) else $error("Secondary bits three-two not zero.");
   mirror_top_zero_a: assert property (
      $past(bus_req_in.rd) && $past(bus_req_in.addr) == cdc_pkg::OFF_MIRROR
      |-> bus_rdata_out[7:2] == 6'h00) else $error("Mirror upper bits not zero.");
   flag_sticky_a: assert property (
      ($past(cmp_irq_flag_out) & ~cmp_irq_flag_out) != 2'h0 |-> $past(bus_req_in.wr)
      && $past(bus_req_in.addr) == cdc_pkg::OFF_IRQ_FLAG) else $error("Flag fell alone.");
   pin_oe_dir_a: assert property (
      $past(rst_n_in) |-> cmp_pin_out[0].oe == !$past(pin_direction_bit_in[0])
      && cmp_pin_out[1].oe == !$past(pin_direction_bit_in[1])) else $error("Pin enable wrong.");
   enable_connect_a: assert property (
      bus_req_in.wr && bus_req_in.addr == cdc_pkg::OFF_CTRL_PRI_ONE |-> ##2
      cmp_analog_ctrl_out[0].connect == $past(bus_req_in.wdata[7], 2)) else $error("Connect.");
   speed_mode_a: assert property (
      bus_req_in.wr && bus_req_in.addr == cdc_pkg::OFF_CTRL_PRI_TWO |-> ##2
      cmp_analog_ctrl_out[1].speed_high == $past(bus_req_in.wdata[2], 2)) else $error("Speed.");
   plus_route_a: assert property (
      bus_req_in.wr && bus_req_in.addr == cdc_pkg::OFF_CTRL_SEC_ONE |-> ##2
      cmp_analog_ctrl_out[0].plus_sel == $past(bus_req_in.wdata[5:4], 2)) else $error("Plus.");
   minus_route_a: assert property (
      bus_req_in.wr && bus_req_in.addr == cdc_pkg::OFF_CTRL_SEC_TWO |-> ##2
      cmp_analog_ctrl_out[1].minus_sel == $past(bus_req_in.wdata[1:0], 2)) else $error("Minus.");
   hyst_mode_a: assert property (
      bus_req_in.wr && bus_req_in.addr == cdc_pkg::OFF_CTRL_PRI_ONE |-> ##2
      cmp_analog_ctrl_out[0].hyst_en == $past(bus_req_in.wdata[1], 2)) else $error("Hyst.");
   flag_seen_c: cover property ($rose(cmp_irq_flag_out[0]));
   gate_seen_c: cover property ($rose(timer_gate_out[0]));
   mirror_read_c: cover property (bus_req_in.rd && bus_req_in.addr == cdc_pkg::OFF_MIRROR);
endmodule
bind cdc_comparator_control cdc_comparator_control_asserts i_cdc_comparator_control_asserts (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .bus_req_in(bus_req_in),
   .bus_rdata_out(bus_rdata_out), .cmp_analog_ctrl_out(cmp_analog_ctrl_out),
   .pin_direction_bit_in(pin_direction_bit_in), .cmp_pin_out(cmp_pin_out),
   .timer_gate_out(timer_gate_out), .cmp_irq_flag_out(cmp_irq_flag_out));
`default_nettype wire

// ---- bench/cdc_analog_model.sv ----
// Behavioural model of the analog cores and the timer clock sources.
`default_nettype none
module cdc_analog_model (
   // Wanted compare levels, pacing and clock run requests.
   input wire logic [1:0] level_in,
   input wire logic slow_in,
   input wire logic [1:0] run_in,
   // Raw results and timer clocks.
   output logic [1:0] raw_out,
   output logic src_clk_out,
   output logic pre_clk_out
);
   timeunit 1ns;
   timeprecision 100ps;
   int unsigned count_q;
   // The core answers after a short or long response; high means plus above minus.
   initial raw_out = 2'h0;
   always @(level_in) begin
      raw_out <= #(slow_in ? 60 : 3) level_in;
   end
   // The source clock runs only on request and comes to rest low.
   initial begin
      src_clk_out = 1'b0;
      pre_clk_out = 1'b0;
      count_q = 0;
      forever begin
         #18.5;
         if (run_in[0] || src_clk_out) src_clk_out = !src_clk_out;
      end
   end
   // The timer counts on the rising edge; the divided clock moves only there.
   always @(posedge src_clk_out) begin
      count_q <= count_q + 1;
      if (run_in[1]) pre_clk_out <= !pre_clk_out;
   end
endmodule
`default_nettype wire

// ---- bench/cdc_comparator_control_bench.sv ----
// Self-checking bench of the comparator control block.
`default_nettype none
module cdc_comparator_control_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   cdc_pkg::cdc_bus_req_t bus_req_in = '0;
   logic [7:0] bus_rdata_out;
   logic [1:0] cmp_raw_in, timer_gate_out, cmp_irq_flag_out;
   cdc_pkg::cdc_analog_ctrl_t [1:0] cmp_analog_ctrl_out;
   cdc_pkg::cdc_pin_t [1:0] cmp_pin_out;
   logic src_clk, pre_clk;
   logic pre_active = 1'b0;
   logic slow = 1'b0;
   logic [1:0] dir = 2'h3, latch = 2'h0, level = 2'h0, run = 2'h0;
   logic [31:0] seed = 32'h20;
   int n_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   // ****************************************************************
   // Instances, clock and helpers.
   // ****************************************************************
   cdc_comparator_control i_cdc_comparator_control (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out), .cmp_raw_in(cmp_raw_in),
      .cmp_analog_ctrl_out(cmp_analog_ctrl_out), .timer_src_clk_in(src_clk),
      .timer_prescaled_clk_in(pre_clk), .timer_prescaler_active_in(pre_active),
      .timer_gate_out(timer_gate_out), .pin_direction_bit_in(dir), .port_latch_in(latch),
      .cmp_pin_out(cmp_pin_out), .cmp_irq_flag_out(cmp_irq_flag_out));
   cdc_analog_model i_cdc_analog_model (.level_in(level), .slow_in(slow), .run_in(run),
      .raw_out(cmp_raw_in), .src_clk_out(src_clk), .pre_clk_out(pre_clk));
   // The clock toggles every half period and a hang is cut short.
   initial forever #2.5 clock_in = !clock_in;
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         results();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // A disabled core shows the invert bit alone.
   function automatic logic res(input logic raw, input logic en, input logic inv);
      return en ? raw ^ inv : inv;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock_in);
      bus_req_in <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clock_in);
      bus_req_in.wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clock_in);
      bus_req_in <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clock_in);
      bus_req_in.rd <= 1'b0;
      #1 chk(bus_rdata_out, exp);
   endtask
   task automatic results();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ****************************************************************
   // Main sequence: reset values, masks, random edges, timer sync.
   // ****************************************************************
   initial begin
      int c;
      logic en, inv, drv, nraw, old, nw, fl;
      logic [1:0] edges, en_s, inv_s;
      repeat (3) @(posedge clock_in);
      rst_n_in <= 1'b1;
      for (int a = 0; a < 8; a++) rd_chk(3'(a), (a == 0 || a == 2) ? 8'h04 : 8'h00);
      wr_reg(cdc_pkg::OFF_CTRL_PRI_ONE, 8'hFF);
      wr_reg(cdc_pkg::OFF_CTRL_SEC_ONE, 8'hFF);
      wr_reg(cdc_pkg::OFF_MIRROR, 8'hFF);
      wr_reg(3'h7, 8'hFF);
      repeat (8) @(posedge clock_in);
      rd_chk(cdc_pkg::OFF_CTRL_PRI_ONE, 8'hF7);
      rd_chk(cdc_pkg::OFF_CTRL_SEC_ONE, 8'hF3);
      rd_chk(cdc_pkg::OFF_MIRROR, 8'h01);
      rd_chk(3'h7, 8'h00);
      en_s = 2'h1;
      inv_s = 2'h1;
      for (int i = 0; i < 40; i++) begin
         @(posedge clock_in);
         c = i % 2;
         seed = xs(seed);
         {nraw, drv, inv, en, edges} = seed[5:0];
         dir[c] <= seed[6];
         latch[c] <= seed[7];
         slow <= seed[14];
         wr_reg(3'(2 * c + 1), {edges, seed[9:8], 2'h0, seed[11:10]});
         wr_reg(3'(2 * c), {en, 1'b0, drv, inv, 1'b0, seed[12], seed[13], 1'b0});
         repeat (8) @(posedge clock_in);
         wr_reg(cdc_pkg::OFF_IRQ_FLAG, 8'h03);
         old = res(level[c], en, inv);
         nw = res(nraw, en, inv);
         fl = (nw && !old && edges[1]) || (!nw && old && edges[0]);
         en_s[c] = en;
         inv_s[c] = inv;
         level[c] <= nraw;
         repeat (24) @(posedge clock_in);
         rd_chk(cdc_pkg::OFF_IRQ_FLAG, {6'h00, c == 1 && fl, c == 0 && fl});
         rd_chk(cdc_pkg::OFF_MIRROR, {6'h00, res(level[1], en_s[1], inv_s[1]),
            res(level[0], en_s[0], inv_s[0])});
         rd_chk(3'(2 * c), {en, nw, drv, inv, 1'b0, seed[12], seed[13], 1'b0});
         chk({6'h00, cmp_pin_out[c].oe, cmp_pin_out[c].value},
            {6'h00, !dir[c], drv ? nw : latch[c]});
         chk({7'h00, timer_gate_out[c]}, {7'h00, nw});
      end
      @(posedge clock_in);
      dir[0] <= 1'b0;
      pre_active <= 1'b1;
      slow <= 1'b0;
      wr_reg(cdc_pkg::OFF_CTRL_PRI_ONE, 8'hA5);
      run <= 2'h3;
      repeat (40) @(posedge clock_in);
      run <= 2'h0;
      old = level[0];
      level[0] <= !old;
      repeat (40) @(posedge clock_in);
      @(negedge clock_in);
      chk({6'h00, timer_gate_out[0], cmp_pin_out[0].value}, {6'h00, old, old});
      run <= 2'h1;
      repeat (40) @(posedge clock_in);
      run <= 2'h0;
      @(negedge clock_in);
      chk({6'h00, timer_gate_out[0], cmp_pin_out[0].value}, {6'h00, old, old});
      run <= 2'h3;
      repeat (40) @(posedge clock_in);
      run <= 2'h0;
      repeat (10) @(posedge clock_in);
      @(negedge clock_in);
      chk({6'h00, timer_gate_out[0], cmp_pin_out[0].value}, {6'h00, !old, !old});
      @(posedge clock_in);
      pre_active <= 1'b0;
      level[0] <= old;
      repeat (10) @(posedge clock_in);
      run <= 2'h1;
      repeat (40) @(posedge clock_in);
      run <= 2'h0;
      repeat (10) @(posedge clock_in);
      @(negedge clock_in);
      chk({6'h00, timer_gate_out[0], cmp_pin_out[0].value}, {6'h00, old, old});
      // An invert toggle on a disabled core sets the flag in the very cycle of its clear.
      wr_reg(cdc_pkg::OFF_CTRL_SEC_TWO, 8'hC0);
      wr_reg(cdc_pkg::OFF_CTRL_PRI_TWO, 8'h00);
      repeat (8) @(posedge clock_in);
      bus_req_in <= '{rd: 1'b0, wr: 1'b1, addr: cdc_pkg::OFF_CTRL_PRI_TWO, wdata: 8'h10};
      @(posedge clock_in);
      bus_req_in.addr <= cdc_pkg::OFF_IRQ_FLAG;
      bus_req_in.wdata <= 8'h03;
      @(posedge clock_in);
      bus_req_in.wr <= 1'b0;
      rd_chk(cdc_pkg::OFF_IRQ_FLAG, 8'h02);
      wr_reg(cdc_pkg::OFF_IRQ_FLAG, 8'h02);
      rd_chk(cdc_pkg::OFF_IRQ_FLAG, 8'h00);
      results();
   end
endmodule
`default_nettype wire
